// >>> dv/fsp_core_model.sv
// core model: store-program, fetch and load
`timescale 1ns/1ps
module fsp_core_model
   import fsp_pkg::*;
(
   // clock
   input wire logic aclk,
   // store-program request
   output logic spi_req,
   output logic spi_write,
   output logic [ADDR_W-1:0] spi_target,
   output logic [ADDR_W-1:0] spi_pc,
   input wire logic spi_started,
   // fetch and load
   output logic fetch_req,
   output logic [ADDR_W-1:0] fetch_addr,
   input wire logic fetch_ok,
   output logic load_req,
   output logic [ADDR_W-1:0] load_addr,
   output logic [ADDR_W-1:0] load_pc,
   input wire logic load_ok
);
   // idle core, interrupts never taken
   initial begin
      {spi_req, spi_write, fetch_req, load_req} = 4'h0;
      {spi_target, spi_pc, fetch_addr, load_addr, load_pc} = '0;
   end
   // one store-program, erase and write alternating
   task automatic store_program_instruction(input logic [ADDR_W-1:0] pc, tgt, output logic ok);
      @(posedge aclk);
      spi_req <= 1'b1;
      spi_write <= ~spi_write;
      spi_pc <= pc;
      spi_target <= tgt;
      @(posedge aclk);
      spi_req <= 1'b0;
      #1;
      ok = spi_started;
   endtask
   // no concurrent fetch unless asked
   task automatic fetch(input logic [ADDR_W-1:0] a, output logic ok);
      @(posedge aclk);
      fetch_req <= 1'b1;
      fetch_addr <= a;
      @(posedge aclk);
      fetch_req <= 1'b0;
      #1;
      ok = fetch_ok;
   endtask
   // program memory load
   task automatic load(input logic [ADDR_W-1:0] pc, a, output logic ok);
      @(posedge aclk);
      load_req <= 1'b1;
      load_pc <= pc;
      load_addr <= a;
      @(posedge aclk);
      load_req <= 1'b0;
      #1;
      ok = load_ok;
   endtask
endmodule

// >>> dv/fsp_flash_ctrl_properties.sv
// port checker for the flash sequencer
`timescale 1ns/1ps
module fsp_flash_ctrl_checker
   import fsp_pkg::*;
#(
   parameter logic [TMR_W-1:0] PROG_CYC = TMR_W'(PROG_CYCLES)
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // core side
   input wire logic spi_req,
   input wire logic [ADDR_W-1:0] spi_target,
   input wire logic [ADDR_W-1:0] spi_pc,
   input wire logic spi_started,
   input wire logic spi_refused,
   input wire logic fetch_req,
   input wire logic [ADDR_W-1:0] fetch_addr,
   input wire logic fetch_ok,
   input wire logic core_stall
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [TMR_W-1:0] stall_cnt_q;
   ////////////////////////////////////////////////////////////////////////
   // cycles in current stall
   always_ff @(posedge aclk) begin
      if (!aresetn || !core_stall) begin
         stall_cnt_q <= '0;
      end else begin
         stall_cnt_q <= stall_cnt_q + 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   spm_answer_a: assert property (
      spi_req |=> spi_started ^ spi_refused)
      else $error("no single answer");
   app_pc_refused_a: assert property (
      spi_req && spi_pc < HALT_START |=> spi_refused)
      else $error("start from app area");
   halt_stall_on_a: assert property (
      (spi_req && spi_target >= HALT_START) ##1 spi_started |-> core_stall)
      else $error("no halt stall");
   halt_stall_len_a: assert property (
      $fell(core_stall) |-> stall_cnt_q == PROG_CYC + 1'b1)
      else $error("stall length wrong");
   rww_no_stall_a: assert property (
      (spi_req && spi_target < HALT_START) ##1 spi_started
      |-> !core_stall ##1 !core_stall)
      else $error("concurrent stall");
   halt_fetch_ok_a: assert property (
      fetch_req && fetch_addr >= HALT_START && !core_stall && !spi_req
      |=> fetch_ok)
      else $error("halt fetch lost");
   rww_fetch_blk_a: assert property (
      fetch_req && fetch_addr < HALT_START && $past(spi_started)
      |=> !fetch_ok)
      else $error("concurrent code served");
   stall_fetch_blk_a: assert property (
      fetch_req && core_stall |=> !fetch_ok)
      else $error("stalled fetch");
   wr_resp_time_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write response late");
   rd_resp_time_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   // main scenarios
   cover property (spi_started && core_stall);
   cover property (spi_started && !core_stall);
   cover property ($fell(core_stall));
endmodule

bind fsp_flash_ctrl fsp_flash_ctrl_checker #(.PROG_CYC(PROG_CYC)) chk_inst (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .spi_req, .spi_target, .spi_pc, .spi_started,
   .spi_refused, .fetch_req, .fetch_addr, .fetch_ok, .core_stall
);

// >>> dv/fsp_flash_ctrl_tb.sv
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
module fsp_flash_ctrl_tb;
   import fsp_pkg::*;
   localparam logic [TMR_W-1:0] PCYC = 16'h0008;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, core_stall, int_inhibit;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic spi_req, spi_write, spi_started, fetch_req, fetch_ok;
   logic load_req, load_ok;
   logic [ADDR_W-1:0] spi_target, spi_pc, fetch_addr, load_addr, load_pc;
   int miscompares = 0, num_checks = 0;
   ////////////////////////////////////////////////////////////////////////
   fsp_flash_ctrl #(.PROG_CYC(PCYC)) fsp_flash_ctrl_inst (
      .aclk, .aresetn, .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .spi_req, .spi_write, .spi_target, .spi_pc,
      .spi_started, .spi_refused(), .fetch_req, .fetch_addr, .fetch_ok,
      .load_req, .load_addr, .load_pc, .load_ok, .core_stall,
      .int_inhibit);
   fsp_core_model fsp_core_model_inst (
      .aclk, .spi_req, .spi_write, .spi_target, .spi_pc, .spi_started,
      .fetch_req, .fetch_addr, .fetch_ok, .load_req, .load_addr,
      .load_pc, .load_ok);
   ////////////////////////////////////////////////////////////////////////
   // clock at 100 MHz
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // wait ran out: a mismatch
   task automatic hang();
      miscompares++;
      $display("wrong value handshake expected answer seen none");
      end_sim();
   endtask
   // bus write, address and data together
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 20) hang();
      chk("bresp", 32'(bresp), 32'(er));
      bready <= 1'b0;
   endtask
   // bus read and compare
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] exp, input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 20) hang();
      chk(nm, rdata, exp);
      chk(nm, 32'(rresp), 32'(er));
      rready <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic ok;
      logic [1:0] c;
      logic [12:0] bnd;
      int n;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("cfg reset", REG_CFG, 32'(CFG_RESET), RESP_OKAY);
      rchk("status reset", REG_STATUS, 32'h0, RESP_OKAY);
      rchk("unmapped rd", 8'h14, 32'h0, RESP_SLVERR);
      wr(8'h14, 32'h1, RESP_SLVERR);
      // boot boundary per fuse code
      for (int i = 0; i < 4; i++) begin
         c = 2'(i);
         bnd = 13'(FLASH_WORDS - (14'h0400 >> i));
         wr(REG_CFG, {26'h0, 4'hF, c}, RESP_OKAY);
         rchk("bound", REG_BOUND, 32'(bnd), RESP_OKAY);
         chk("bound halt", 32'(bnd >= HALT_START), 32'h1);
         fsp_core_model_inst.store_program_instruction(bnd - 13'h1, 13'h0200, ok);
         chk("spm below bound", 32'(ok), 32'h0);
      end
      // each lock code per area, other area free
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(REG_CFG, j ? {26'h0, c, 4'hF} : {26'h0, 2'h3, c, 2'h3},
               RESP_OKAY);
            fsp_core_model_inst.load(j ? 13'h0100 : 13'h1FF0,
               j ? 13'h1F90 : 13'h0200, ok);
            chk("load lock", 32'(ok), 32'(c[1]));
            fsp_core_model_inst.store_program_instruction(13'h1FF0, j ? 13'h1F80 : 13'h0200, ok);
            chk("spm lock", 32'(ok), 32'(c[0]));
            repeat (PCYC + 3) @(posedge aclk);
            wr(REG_CTRL, 32'h1, RESP_OKAY);
         end
      end
      // concurrent page: halting code runs
      wr(REG_CFG, 32'(CFG_RESET), RESP_OKAY);
      fsp_core_model_inst.store_program_instruction(13'h1FF0, 13'h0200, ok);
      chk("rww start", 32'(ok), 32'h1);
      chk("rww stall", 32'(core_stall), 32'h0);
      fsp_core_model_inst.fetch(13'h0300, ok);
      chk("rww fetch", 32'(ok), 32'h0);
      fsp_core_model_inst.fetch(13'h1E00, ok);
      chk("halt fetch", 32'(ok), 32'h1);
      repeat (PCYC + 3) @(posedge aclk);
      rchk("busy held", REG_STATUS, 32'h1, RESP_OKAY);
      fsp_core_model_inst.fetch(13'h0300, ok);
      chk("rww fetch busy", 32'(ok), 32'h0);
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      rchk("busy clear", REG_STATUS, 32'h0, RESP_OKAY);
      fsp_core_model_inst.fetch(13'h0300, ok);
      chk("rww fetch free", 32'(ok), 32'h1);
      // halting page: whole operation stalls
      fsp_core_model_inst.store_program_instruction(13'h1FF0, 13'h1F80, ok);
      chk("halt stall", 32'(core_stall), 32'h1);
      fsp_core_model_inst.fetch(13'h1E00, ok);
      chk("stalled fetch", 32'(ok), 32'h0);
      n = 0;
      while (core_stall && n < 50) begin
         @(posedge aclk);
         #1;
         n++;
      end
      chk("stall rest", 32'(n), 32'(PCYC - 16'h1));
      fsp_core_model_inst.fetch(13'h1E00, ok);
      chk("resume fetch", 32'(ok), 32'h1);
      wr(REG_CTRL, 32'h1, RESP_OKAY);
      // vectors in boot, app load-locked, running in app
      wr(REG_CFG, 32'h00000073, RESP_OKAY);
      fsp_core_model_inst.fetch(13'h0100, ok);
      repeat (2) @(posedge aclk);
      #1;
      chk("int inhibit", 32'(int_inhibit), 32'h1);
      rchk("refcnt", REG_REFCNT, 32'h8, RESP_OKAY);
      end_sim();
   end
endmodule

// >>> logic/fsp_flash_ctrl.sv
// self-programming control with concurrent read and halting regions
//
// Functional notes
// - store-program starts an operation only when executed from boot area
// - from the boot area it may target any flash word, boot included
// - boot area boundary follows the boot-size fuse code
// - application area protection comes from the application lock pair
// - boot area protection comes from the boot lock pair
// - the two lock pairs act independently of each other
// - flash is also split into fixed concurrent and halting regions
// - stall decision uses the target page address, not the fetch
// - concurrent-region operation keeps serving halting-region reads
// - halting-region operation stalls the core for its whole length
// - no valid concurrent-region code is delivered during programming
// - boot area always lies wholly inside the halting region
// - busy flag reads one while the concurrent region is blocked
// - application lock codes: 11 free, 10 no write, 00 both, 01 no load
// - boot lock codes use the same four modes, areas swapped
`timescale 1ns/1ps
module fsp_flash_ctrl
   import fsp_pkg::*;
#(
   parameter logic [TMR_W-1:0] PROG_CYC = TMR_W'(PROG_CYCLES)
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // store-program request from the core
   input wire logic spi_req,
   input wire logic spi_write,
   input wire logic [ADDR_W-1:0] spi_target,
   input wire logic [ADDR_W-1:0] spi_pc,
   output logic spi_started,
   output logic spi_refused,
   // instruction fetch
   input wire logic fetch_req,
   input wire logic [ADDR_W-1:0] fetch_addr,
   output logic fetch_ok,
   // program memory load
   input wire logic load_req,
   input wire logic [ADDR_W-1:0] load_addr,
   input wire logic [ADDR_W-1:0] load_pc,
   output logic load_ok,
   // core control
   output logic core_stall,
   output logic int_inhibit
);

   ////////////////////////////////////////////////////////////////////
   // configuration, status and classification signals

   logic [6:0] cfg_q;
   logic busy_q;
   logic active_q;
   logic tgt_halt_q;
   logic refused_q;
   logic [7:0] refcnt_q;
   logic started_q;
   logic refpulse_q;
   logic fetch_ok_q;
   logic load_ok_q;
   logic inhibit_q;

   logic [1:0] boot_size;
   logic [1:0] app_lock;
   logic [1:0] boot_lock;
   logic vec_in_boot;

   logic tgt_boot, tgt_halt, pc_boot;
   logic fet_boot, fet_halt;
   logic ld_boot, ld_halt, ldpc_boot;
   logic [ADDR_W-1:0] boot_start;

   logic tmr_run, tmr_done;
   logic spi_accept;
   logic spi_lock_ok;
   logic busy_clr;

   // fuse and lock fields
   assign boot_size = cfg_q[CFG_BOOT_SIZE_FUSES_LSB +: 2];
   assign app_lock = cfg_q[CFG_APPLOCK_LSB +: 2];
   assign boot_lock = cfg_q[CFG_BOOTLOCK_LSB +: 2];
   assign vec_in_boot = cfg_q[CFG_VEC_BOOT_BIT];

   ////////////////////////////////////////////////////////////////////
   // address classification

   // target page of the store-program request
   fsp_region_map u_map_tgt (
      .addr(spi_target),
      .boot_size(boot_size),
      .in_boot(tgt_boot),
      .in_halt(tgt_halt),
      .boot_start(boot_start)
   );

   // location of the store-program instruction itself
   fsp_region_map u_map_pc (
      .addr(spi_pc),
      .boot_size(boot_size),
      .in_boot(pc_boot),
      .in_halt(),
      .boot_start()
   );

   // fetch address, also the current execution point
   fsp_region_map u_map_fetch (
      .addr(fetch_addr),
      .boot_size(boot_size),
      .in_boot(fet_boot),
      .in_halt(fet_halt),
      .boot_start()
   );

   // load address
   fsp_region_map u_map_load (
      .addr(load_addr),
      .boot_size(boot_size),
      .in_boot(ld_boot),
      .in_halt(ld_halt),
      .boot_start()
   );

   // location of the load instruction
   fsp_region_map u_map_ldpc (
      .addr(load_pc),
      .boot_size(boot_size),
      .in_boot(ldpc_boot),
      .in_halt(),
      .boot_start()
   );

   ////////////////////////////////////////////////////////////////////
   // store-program acceptance

   // each area checks only its own lock pair
   assign spi_lock_ok = tgt_boot ? !lock_wr_blocked(boot_lock)
                                 : !lock_wr_blocked(app_lock);
   // any target word is reachable from the boot area
   assign spi_accept = spi_req && pc_boot && !active_q
                       && spi_lock_ok;

   // page operation duration
   fsp_op_timer #(
      .CYCLES(PROG_CYC)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(spi_accept),
      .running(tmr_run),
      .done(tmr_done)
   );

   // operation state and stall region from the target page
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_q <= 1'b0;
         tgt_halt_q <= 1'b0;
      end else if (spi_accept) begin
         active_q <= 1'b1;
         tgt_halt_q <= tgt_halt;
      end else if (tmr_done) begin
         active_q <= 1'b0;
         tgt_halt_q <= 1'b0;
      end
   end

   // one-cycle start and refusal pulses, refusal history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         started_q <= 1'b0;
         refpulse_q <= 1'b0;
         refused_q <= 1'b0;
         refcnt_q <= 8'h00;
      end else begin
         started_q <= spi_accept;
         refpulse_q <= spi_req && !spi_accept;
         if (spi_accept) begin
            refused_q <= 1'b0;
         end else if (spi_req) begin
            refused_q <= 1'b1;
            refcnt_q <= refcnt_q + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // concurrent region busy flag

   // set by any operation, held until software clears it afterwards
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_q <= 1'b0;
      end else if (spi_accept || active_q) begin
         busy_q <= 1'b1;
      end else if (busy_clr) begin
         busy_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // fetch and load qualification

   // concurrent code is invalid while blocked; halting code stays live except during a halting-region operation
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fetch_ok_q <= 1'b0;
      end else begin
         fetch_ok_q <= fetch_req && (fet_halt
                       || !busy_q)
                       && !(active_q && tgt_halt_q);
      end
   end

   // loads obey blocking and the cross-area read locks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_ok_q <= 1'b0;
      end else begin
         load_ok_q <= load_req && (ld_halt || !busy_q)
            && !(active_q && tgt_halt_q)
            && !(ldpc_boot && !ld_boot
                 && lock_rd_blocked(app_lock))
            && !(!ldpc_boot && ld_boot
                 && lock_rd_blocked(boot_lock));
      end
   end

   // interrupts off while executing in a read-locked area with the vectors in the other area
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         inhibit_q <= 1'b0;
      end else begin
         inhibit_q <= (vec_in_boot && !fet_boot
                       && lock_rd_blocked(app_lock))
                   || (!vec_in_boot && fet_boot
                       && lock_rd_blocked(boot_lock));
      end
   end

   // core outputs
   assign core_stall = active_q && tgt_halt_q;
   assign spi_started = started_q;
   assign spi_refused = refpulse_q;
   assign fetch_ok = fetch_ok_q;
   assign load_ok = load_ok_q;
   assign int_inhibit = inhibit_q;

   ////////////////////////////////////////////////////////////////////
   // axi4-lite write channel

   logic aw_have_q, w_have_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic wr_fire;

   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

   // capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // write response once both halves are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         if (aw_addr_q == REG_CFG || aw_addr_q == REG_CTRL) begin
            bresp_q <= RESP_OKAY;
         end else if (aw_addr_q == REG_STATUS
                      || aw_addr_q == REG_BOUND
                      || aw_addr_q == REG_REFCNT) begin
            bresp_q <= RESP_OKAY; // read-only, write ignored
         end else begin
            bresp_q <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // configuration register update
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= CFG_RESET;
      end else if (wr_fire && aw_addr_q == REG_CFG && w_strb_q[0]) begin
         cfg_q <= w_data_q[6:0];
      end
   end

   // write-one action on the control register
   assign busy_clr = wr_fire && aw_addr_q == REG_CTRL && w_strb_q[0]
                     && w_data_q[CTRL_BUSY_CLR_BIT];

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   ////////////////////////////////////////////////////////////////////
   // axi4-lite read channel

   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [31:0] rd_word;
   logic rd_hit;

   assign s_axi_arready = !rvalid_q;

   // read decode
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      if (s_axi_araddr == REG_CFG) begin
         rd_word[6:0] = cfg_q;
      end else if (s_axi_araddr == REG_CTRL) begin
         rd_word = 32'h0000_0000;
      end else if (s_axi_araddr == REG_STATUS) begin
         rd_word[ST_BUSY_BIT] = busy_q;
         rd_word[ST_ACTIVE_BIT] = active_q && tmr_run;
         rd_word[ST_STALL_BIT] = core_stall;
         rd_word[ST_REFUSED_BIT] = refused_q;
         rd_word[ST_TGT_HALT_BIT] = tgt_halt_q;
      end else if (s_axi_araddr == REG_BOUND) begin
         rd_word[ADDR_W-1:0] = boot_start;
      end else if (s_axi_araddr == REG_REFCNT) begin
         rd_word[7:0] = refcnt_q;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // registered read answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

endmodule

// >>> logic/fsp_op_timer.sv
// page erase/write duration timer
`timescale 1ns/1ps
module fsp_op_timer
   import fsp_pkg::*;
#(
   parameter logic [TMR_W-1:0] CYCLES = TMR_W'(PROG_CYCLES)
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic start,
   output logic running,
   output logic done
);

   logic [TMR_W-1:0] cnt_q;
   logic run_q;
   logic done_q;

   // count down one operation
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start && !run_q) begin
            cnt_q <= CYCLES - TMR_W'(1);
            run_q <= 1'b1;
         end else if (run_q) begin
            if (cnt_q == '0) begin
               run_q <= 1'b0;
               done_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q - TMR_W'(1);
            end
         end
      end
   end

   assign running = run_q;
   assign done = done_q;

endmodule

// >>> logic/fsp_pkg.sv
// shared constants, register map and lock decoding for the flash sequencer
package fsp_pkg;

   // flash geometry in 16-bit words
   localparam int ADDR_W = 13;
   localparam logic [ADDR_W:0] FLASH_WORDS = 14'h2000;
   // fixed start of the halting region (upper part of flash)
   localparam logic [ADDR_W-1:0] HALT_START = 13'h1C00;

   // boot area size per boot-size fuse code
   localparam logic [ADDR_W:0] BOOT_WORDS_11 = 14'h0080;
   localparam logic [ADDR_W:0] BOOT_WORDS_10 = 14'h0100;
   localparam logic [ADDR_W:0] BOOT_WORDS_01 = 14'h0200;
   localparam logic [ADDR_W:0] BOOT_WORDS_00 = 14'h0400;

   // duration of one page erase or write
   localparam int PROG_TIME_NS = 4000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
   localparam int TMR_W = 16;

   // register byte offsets
   localparam logic [7:0] REG_CFG = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_BOUND = 8'h0C;
   localparam logic [7:0] REG_REFCNT = 8'h10;

   // configuration field positions
   localparam int CFG_BOOT_SIZE_FUSES_LSB = 0;
   localparam int CFG_APPLOCK_LSB = 2;
   localparam int CFG_BOOTLOCK_LSB = 4;
   localparam int CFG_VEC_BOOT_BIT = 6;
   localparam logic [6:0] CFG_RESET = 7'h3F;
   // control field: write one clears the busy flag
   localparam int CTRL_BUSY_CLR_BIT = 0;
   // status field positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ACTIVE_BIT = 1;
   localparam int ST_STALL_BIT = 2;
   localparam int ST_REFUSED_BIT = 3;
   localparam int ST_TGT_HALT_BIT = 4;

   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // lock code {high, low}: 1 means unprogrammed
   localparam logic [1:0] LOCK_NONE = 2'h3;
   localparam logic [1:0] LOCK_NOWR = 2'h2;
   localparam logic [1:0] LOCK_ALL = 2'h0;
   localparam logic [1:0] LOCK_NORD = 2'h1;

   // lock code forbids the store-program instruction writing the area
   function automatic logic lock_wr_blocked(input logic [1:0] code);
      return (code == LOCK_NOWR) || (code == LOCK_ALL);
   endfunction

   // lock code forbids loads from the other area reading this area
   function automatic logic lock_rd_blocked(input logic [1:0] code);
      return (code == LOCK_ALL) || (code == LOCK_NORD);
   endfunction

endpackage

// >>> logic/fsp_region_map.sv
// address classifier: boot area, halting region and boot boundary
`timescale 1ns/1ps
module fsp_region_map
   import fsp_pkg::*;
(
   // address under test and fuse setting
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [1:0] boot_size,
   // classification
   output logic in_boot,
   output logic in_halt,
   output logic [ADDR_W-1:0] boot_start
);

   logic [ADDR_W:0] boot_words;
   logic [ADDR_W:0] start_wide;

   // boot area size from the fuse code
   always_comb begin
      case (boot_size)
         2'h3: boot_words = BOOT_WORDS_11;
         2'h2: boot_words = BOOT_WORDS_10;
         2'h1: boot_words = BOOT_WORDS_01;
         default: boot_words = BOOT_WORDS_00;
      endcase
   end

   // boot area sits at the top of flash
   assign start_wide = FLASH_WORDS - boot_words;
   assign boot_start = start_wide[ADDR_W-1:0];
   assign in_boot = (addr >= boot_start);
   // fixed split, independent of the fuses
   assign in_halt = (addr >= HALT_START);

endmodule
